// file: ecd_consts.svh
// constants of the electrophoretic panel command decoder
// ****************************************************************
// How it works
// ****************************************************************
// How it works
// - power-down command runs sequence, then busy output
// - power-down stops drivers, keeps state; only when on
// - power-up command raises busy when supplies ready
// - deep sleep needs check byte; only reset leaves
// - auto sequence runs on, refresh, off, maybe sleep
// - data bytes hold four pixels, earliest in MSBs
// - pixel code picks gray level 0 to 3
// - refresh drives panel from memory, busy until done
// - temperature sense holds busy, then returns one byte
// - border bits 7..5 select level or high impedance
// - resolution takes four bytes, two 10-bit values
// - last received resolution source wins; a serial byte beats a port write in the same cycle
// - version command returns fixed identifier byte
// - vcom auto byte codes points, time, enable
// - vcom sensing only when on, busy until done
// - vcom read returns 10 tag and measured value
// - vcom level byte holds source select and code
// - program mode entry holds busy; reset leaves
// - otp write needs power on, busy until done
// - otp read gives dummy then bytes from zero
// - select low marks command, high marks data
`ifndef ECD_CONSTS_SVH
`define ECD_CONSTS_SVH
// ****************************************************************
// command codes
// ****************************************************************
`define ECD_C_PDOWN   8'h02
`define ECD_C_PUP     8'h04
`define ECD_C_SLEEP   8'h07
`define ECD_C_IMG     8'h10
`define ECD_C_REFR    8'h12
`define ECD_C_AUTO    8'h17
`define ECD_C_TEMP    8'h40
`define ECD_C_BORDER  8'h50
`define ECD_C_RES     8'h61
`define ECD_C_VER     8'h70
`define ECD_C_VAUTO   8'h80
`define ECD_C_VREAD   8'h81
`define ECD_C_VDC     8'h82
`define ECD_C_OTPMODE 8'h90
`define ECD_C_OTPWR   8'h91
`define ECD_C_OTPRD   8'h92
`define ECD_C_PSAVE   8'he3
// ****************************************************************
// parameter values, reset values and timing
// ****************************************************************
`define ECD_SLEEP_KEY  8'ha5
`define ECD_AUTO_PLAIN 8'ha5
`define ECD_AUTO_SLEEP 8'ha7
`define ECD_BORDER_RST 8'h97
`define ECD_VAUTO_RST  8'h00
`define ECD_VDC_RST    8'h00
`define ECD_PSAVE_RST  8'h65
`define ECD_HORIZONTAL_RESOLUTION_RST   10'h3c0
`define ECD_VERTICAL_RESOLUTION_RST   10'h2a8
`define ECD_BORDER_HIZ 3'h4
`define ECD_VREAD_TAG  2'h2
`define ECD_OTP_DUMMY  8'h00
`define ECD_CLK_NS     8
`define ECD_PON_NS     80000000
`define ECD_SEC_NS     1000000000
`define ECD_SENSE_STEP 5
`endif

// file: ecd_pkg.sv
// types shared by the command decoder
package ecd_pkg;
   typedef enum logic [2:0] {
      ECD_IDLE    = 3'h0,
      ECD_PWRUP   = 3'h1,
      ECD_REFRESH = 3'h3,
      ECD_PWRDN   = 3'h2,
      ECD_TEMP    = 3'h6,
      ECD_VSENSE  = 3'h7,
      ECD_OTPMODE = 3'h5,
      ECD_OTPWR   = 3'h4
   } ecd_seq_type;
endpackage

// file: ecd_frame_mem.sv
// frame memory: one write port, registered read port
`timescale 1ns/10ps
module ecd_frame_mem #(
   parameter int DW    = 8,
   parameter int AW    = 18,
   parameter int DEPTH = 163200
) (
   input  wire logic          clk,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output logic      [DW-1:0] rdData
);
   logic [DW-1:0] mem [DEPTH];

   // writes past the end are dropped rather than aliased
   always_ff @(posedge clk) begin
      if (wrEn && (int'(wrAddr) < DEPTH)) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

// file: ecd_decoder.sv
// command decoder: serial byte link, command sequencer, settings
`timescale 1ns/10ps
`include "ecd_consts.svh"
module ecd_decoder #(
   parameter int          AW       = 18,
   parameter int          DEPTH    = 163200,
   parameter int unsigned PON_CYC  =
      (`ECD_PON_NS + `ECD_CLK_NS - 1) / `ECD_CLK_NS,
   parameter int unsigned SEC_CYC  = `ECD_SEC_NS / `ECD_CLK_NS,
   parameter int unsigned POF_CYC  = 1000,
   parameter int unsigned REF_CYC  = 1000,
   parameter int unsigned TEMP_CYC = 1000,
   parameter int unsigned MODE_CYC = 1000,
   parameter int unsigned PROG_CYC = 1000,
   // arbitrary value
   parameter logic [7:0]  VER_ID   = 8'h3c
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        sclk,
   input  wire logic        csN,
   input  wire logic        dcSel,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   output logic             busyN,
   output logic             powerOn,
   output logic             tempSensorEn,
   output logic             deepSleep,
   output logic             programMode,
   output logic             otpProgStart,
   output logic [15:0]      otpAddr,
   input  wire logic [7:0]  otpRdData,
   input  wire logic [7:0]  tempValue,
   input  wire logic [5:0]  vcomSense,
   input  wire logic        psrResWr,
   input  wire logic [9:0]  psrHres,
   input  wire logic [9:0]  psrVres,
   output logic [9:0]       horizontal_resolution,
   output logic [9:0]       vertical_resolution,
   output logic [2:0]       borderSel,
   output logic             borderHiZ,
   output logic [7:0]       vcomDc,
   output logic [7:0]       vcomAutoCfg,
   output logic [7:0]       powerSaving,
   output logic [1:0]       srcLevel,
   output logic             srcValid
);
   import ecd_pkg::*;
   localparam int SW = AW + 2;

   // ****************************************************************
   // link side, clocked by the host's serial clock
   // ****************************************************************
   logic [2:0] bitCnt_q;
   logic [6:0] rxSh_q;
   logic [7:0] rxByte_q;
   logic       rxDc_q;
   logic       rxTog_q;
   logic [7:0] rdByte_q;
   logic       rdActive_q;
   wire        linkRst = csN | ~resetn;

   // deselect restarts the bit count, so a frame always starts aligned
   always_ff @(posedge sclk or posedge linkRst) begin
      if (linkRst) begin
         bitCnt_q <= 3'h0;
         rxSh_q   <= 7'h00;
      end else begin
         bitCnt_q <= bitCnt_q + 3'h1;
         rxSh_q   <= {rxSh_q[5:0], sdaIn};
      end
   end

   // byte and its select stay still for 8 serial clocks after the toggle
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rxByte_q <= 8'h00;
         rxDc_q   <= 1'b0;
         rxTog_q  <= 1'b0;
      end else if (!csN && bitCnt_q == 3'h7) begin
         rxByte_q <= {rxSh_q, sdaIn};
         rxDc_q   <= dcSel;
         rxTog_q  <= ~rxTog_q;
      end
   end

   // read byte is held steady by the main side between read bytes
   assign sdaOut = rdByte_q[3'h7 - bitCnt_q];
   assign sdaOe  = rdActive_q & ~csN & dcSel;

   // ****************************************************************
   // byte events in the main domain
   // ****************************************************************
   logic [2:0] togSync_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         togSync_q <= 3'h0;
      end else begin
         togSync_q <= {togSync_q[1:0], rxTog_q};
      end
   end

   ecd_seq_type seq_q;
   logic [31:0] timer_q;
   logic        poweredOn_q;
   logic        autoSeq_q;
   logic        autoSleep_q;
   logic        deepSleep_q;
   logic        progMode_q;
   logic [7:0]  cmd_q;
   logic        cmdVld_q;
   logic [1:0]  pIdx_q;
   logic        scanDone_q;

   wire [7:0] rxb     = rxByte_q;
   wire       byteEv  = togSync_q[2] ^ togSync_q[1];
   wire       live    = ~deepSleep_q;
   wire       isCmd   = byteEv & ~rxDc_q & live;
   wire       datEv   = byteEv & rxDc_q & live;
   wire       prm     = datEv & cmdVld_q & ~rdActive_q;
   wire       rdEv    = datEv & rdActive_q;
   wire       seqIdle = (seq_q == ECD_IDLE);
   wire       tDone   = (timer_q == 32'h0);
   wire       first   = (pIdx_q == 2'h0);
   wire       known   = (rxb == `ECD_C_PDOWN) | (rxb == `ECD_C_PUP)
      | (rxb == `ECD_C_SLEEP) | (rxb == `ECD_C_IMG)
      | (rxb == `ECD_C_REFR) | (rxb == `ECD_C_AUTO)
      | (rxb == `ECD_C_TEMP) | (rxb == `ECD_C_BORDER)
      | (rxb == `ECD_C_RES) | (rxb == `ECD_C_VER)
      | (rxb == `ECD_C_VAUTO) | (rxb == `ECD_C_VREAD)
      | (rxb == `ECD_C_VDC) | (rxb == `ECD_C_OTPMODE)
      | (rxb == `ECD_C_OTPWR) | (rxb == `ECD_C_OTPRD)
      | (rxb == `ECD_C_PSAVE);

   // long operations only start from idle; the host waits out busy
   wire goPdown = isCmd & seqIdle & poweredOn_q
      & (rxb == `ECD_C_PDOWN);
   wire goPup   = isCmd & seqIdle & ~poweredOn_q & (rxb == `ECD_C_PUP);
   wire goRefr  = isCmd & seqIdle & (rxb == `ECD_C_REFR);
   wire goTemp  = isCmd & seqIdle & (rxb == `ECD_C_TEMP);
   wire goMode  = isCmd & seqIdle & (rxb == `ECD_C_OTPMODE);
   wire goOtpWr = isCmd & seqIdle & poweredOn_q
      & (rxb == `ECD_C_OTPWR);
   wire goAuto  = prm & first & seqIdle & (cmd_q == `ECD_C_AUTO)
      & ((rxb == `ECD_AUTO_PLAIN) | (rxb == `ECD_AUTO_SLEEP));
   wire goVs    = prm & first & seqIdle & (cmd_q == `ECD_C_VAUTO)
      & rxb[0] & poweredOn_q;
   wire goSleep = prm & first & seqIdle & (cmd_q == `ECD_C_SLEEP)
      & (rxb == `ECD_SLEEP_KEY);
   wire imgWr   = prm & (cmd_q == `ECD_C_IMG);
   wire anyGo   = goPdown | goPup | goRefr | goTemp | goMode | goOtpWr
      | goAuto | goVs;

   // sensing time is 5, 10, 15 or 20 seconds
   wire [31:0] senseCyc = 32'(SEC_CYC) * 32'(`ECD_SENSE_STEP)
      * {29'h0, {1'b0, rxb[5:4]} + 3'h1};

   ecd_seq_type goSt;
   logic [31:0] goCnt;
   assign goSt = (goPup | goAuto) ? ECD_PWRUP
               : goPdown          ? ECD_PWRDN
               : goRefr           ? ECD_REFRESH
               : goTemp           ? ECD_TEMP
               : goVs             ? ECD_VSENSE
               : goMode           ? ECD_OTPMODE
               :                    ECD_OTPWR;
   assign goCnt = (goPup | goAuto) ? 32'(PON_CYC - 1)
                : goPdown          ? 32'(POF_CYC - 1)
                : goRefr           ? 32'(REF_CYC - 1)
                : goTemp           ? 32'(TEMP_CYC - 1)
                : goVs             ? senseCyc - 32'h1
                : goMode           ? 32'(MODE_CYC - 1)
                :                    32'(PROG_CYC - 1);

   // ****************************************************************
   // operation sequencer
   // ****************************************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         seq_q       <= ECD_IDLE;
         timer_q     <= 32'h0;
         poweredOn_q <= 1'b0;
         autoSeq_q   <= 1'b0;
         autoSleep_q <= 1'b0;
         deepSleep_q <= 1'b0;
         progMode_q  <= 1'b0;
      end else begin
         timer_q <= tDone ? timer_q : timer_q - 32'h1;
         case (seq_q)
            ECD_IDLE: begin
               if (anyGo) begin
                  seq_q   <= goSt;
                  timer_q <= goCnt;
               end
               if (goAuto) begin
                  autoSeq_q   <= 1'b1;
                  autoSleep_q <= (rxb == `ECD_AUTO_SLEEP);
               end
               if (goMode) begin
                  progMode_q <= 1'b1;
               end
               if (goSleep) begin
                  deepSleep_q <= 1'b1;
                  poweredOn_q <= 1'b0;
               end
            end
            ECD_PWRUP: begin
               if (tDone) begin
                  poweredOn_q <= 1'b1;
                  seq_q       <= autoSeq_q ? ECD_REFRESH : ECD_IDLE;
                  timer_q     <= 32'(REF_CYC - 1);
               end
            end
            ECD_REFRESH: begin
               if (tDone && scanDone_q) begin
                  seq_q   <= autoSeq_q ? ECD_PWRDN : ECD_IDLE;
                  timer_q <= 32'(POF_CYC - 1);
               end
            end
            ECD_PWRDN: begin
               if (tDone) begin
                  poweredOn_q <= 1'b0;
                  seq_q       <= ECD_IDLE;
                  autoSeq_q   <= 1'b0;
                  deepSleep_q <= autoSeq_q & autoSleep_q;
               end
            end
            default: begin
               if (tDone) begin
                  seq_q <= ECD_IDLE;
               end
            end
         endcase
      end
   end

   assign busyN        = seqIdle;
   assign powerOn      = poweredOn_q;
   assign tempSensorEn = (seq_q == ECD_TEMP);
   assign deepSleep    = deepSleep_q;
   assign programMode  = progMode_q;

   // ****************************************************************
   // command tracking, read data and image writes
   // ****************************************************************
   logic [AW-1:0] wrAddr_q;
   logic [15:0]   otpAddr_q;
   logic          rdOtp_q;
   logic [5:0]    vMeas_q;
   logic          progGo_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_q      <= 8'h00;
         cmdVld_q   <= 1'b0;
         pIdx_q     <= 2'h0;
         wrAddr_q   <= '0;
         rdActive_q <= 1'b0;
         rdOtp_q    <= 1'b0;
         rdByte_q   <= 8'h00;
         otpAddr_q  <= 16'h0000;
         vMeas_q    <= 6'h00;
         progGo_q   <= 1'b0;
      end else begin
         progGo_q <= goOtpWr;
         if (isCmd) begin
            cmd_q      <= rxb;
            cmdVld_q   <= known;
            pIdx_q     <= 2'h0;
            rdActive_q <= (rxb == `ECD_C_TEMP) | (rxb == `ECD_C_VER)
               | (rxb == `ECD_C_VREAD) | (rxb == `ECD_C_OTPRD);
            rdOtp_q    <= (rxb == `ECD_C_OTPRD);
            if (rxb == `ECD_C_IMG) begin
               wrAddr_q <= '0;
            end
            if (rxb == `ECD_C_VER) begin
               rdByte_q <= VER_ID;
            end
            if (rxb == `ECD_C_VREAD) begin
               rdByte_q <= {`ECD_VREAD_TAG, vMeas_q};
            end
            if (rxb == `ECD_C_OTPRD) begin
               rdByte_q  <= `ECD_OTP_DUMMY;
               otpAddr_q <= 16'h0000;
            end
         end else if (rdEv && rdOtp_q) begin
            rdByte_q  <= otpRdData;
            otpAddr_q <= otpAddr_q + 16'h1;
         end else if (seq_q == ECD_TEMP && tDone) begin
            rdByte_q <= tempValue;
         end
         if (prm && pIdx_q != 2'h3) begin
            pIdx_q <= pIdx_q + 2'h1;
         end
         if (imgWr) begin
            wrAddr_q <= wrAddr_q + 1'b1;
         end
         if (seq_q == ECD_VSENSE && tDone) begin
            vMeas_q <= vcomSense;
         end
      end
   end

   assign otpAddr      = otpAddr_q;
   assign otpProgStart = progGo_q;

   // ****************************************************************
   // settings written by parameter bytes
   // ****************************************************************
   logic [7:0] border_q;
   logic [7:0] vAuto_q;
   logic [7:0] vDc_q;
   logic [7:0] pSave_q;
   logic [9:0] horizontal_resolution_q;
   logic [9:0] vertical_resolution_q;
   logic [9:0] hNew_q;
   logic [1:0] vHi_q;
   wire        pOne = prm & first;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         border_q <= `ECD_BORDER_RST;
         vAuto_q  <= `ECD_VAUTO_RST;
         vDc_q    <= `ECD_VDC_RST;
         pSave_q  <= `ECD_PSAVE_RST;
         horizontal_resolution_q   <= `ECD_HORIZONTAL_RESOLUTION_RST;
         vertical_resolution_q   <= `ECD_VERTICAL_RESOLUTION_RST;
         hNew_q   <= 10'h000;
         vHi_q    <= 2'h0;
      end else begin
         if (pOne && cmd_q == `ECD_C_BORDER) begin
            border_q <= rxb;
         end
         if (pOne && cmd_q == `ECD_C_VAUTO) begin
            vAuto_q <= rxb;
         end
         if (pOne && cmd_q == `ECD_C_VDC) begin
            vDc_q <= rxb;
         end
         if (pOne && cmd_q == `ECD_C_PSAVE) begin
            pSave_q <= rxb;
         end
         if (prm && cmd_q == `ECD_C_RES) begin
            case (pIdx_q)
               2'h0: hNew_q[9:8] <= rxb[1:0];
               2'h1: hNew_q[7:0] <= rxb;
               2'h2: vHi_q       <= rxb[1:0];
               default: begin
                  horizontal_resolution_q <= hNew_q;
                  vertical_resolution_q <= {vHi_q, rxb};
               end
            endcase
         end else if (psrResWr) begin
            horizontal_resolution_q <= psrHres;
            vertical_resolution_q <= psrVres;
         end
      end
   end

   assign horizontal_resolution        = horizontal_resolution_q;
   assign vertical_resolution        = vertical_resolution_q;
   assign borderSel   = border_q[7:5];
   assign borderHiZ   = (border_q[7:5] == `ECD_BORDER_HIZ);
   assign vcomAutoCfg = vAuto_q;
   assign vcomDc      = vDc_q;
   assign powerSaving = pSave_q;

   // ****************************************************************
   // refresh scan of frame memory
   // ****************************************************************
   logic [SW-1:0] scan_q;
   logic [1:0]    sel1_q;
   logic          vld1_q;
   logic [1:0]    level_q;
   logic          srcVld_q;
   logic [7:0]    rdData;

   // width is a multiple of four, so bytes never straddle lines
   wire [19:0]    pixTotal = {10'h000, horizontal_resolution_q} * {10'h000, vertical_resolution_q};
   wire [SW-1:0]  lastPix  = SW'(pixTotal - 20'h1);
   wire           scanning = (seq_q == ECD_REFRESH) & ~scanDone_q;
   wire [7:0]     pixShift = rdData >> {~sel1_q, 1'b0};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scan_q     <= '0;
         scanDone_q <= 1'b0;
         sel1_q     <= 2'h0;
         vld1_q     <= 1'b0;
         level_q    <= 2'h0;
         srcVld_q   <= 1'b0;
      end else begin
         if (seq_q != ECD_REFRESH) begin
            scan_q     <= '0;
            scanDone_q <= 1'b0;
         end else if (!scanDone_q) begin
            scan_q     <= scan_q + 1'b1;
            scanDone_q <= (scan_q == lastPix);
         end
         sel1_q   <= scan_q[1:0];
         vld1_q   <= scanning;
         level_q  <= pixShift[1:0];
         srcVld_q <= vld1_q;
      end
   end

   assign srcLevel = level_q;
   assign srcValid = srcVld_q;

   ecd_frame_mem #(
      .DW    (8),
      .AW    (AW),
      .DEPTH (DEPTH)
   ) frameMem (
      .clk    (mclk),
      .wrEn   (imgWr),
      .wrAddr (wrAddr_q),
      .wrData (rxb),
      .rdAddr (scan_q[SW-1:2]),
      .rdData (rdData)
   );

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   pdown_start_a: assert property (
      goPdown |=> (!busyN && seq_q == ECD_PWRDN))
      else $error("power-down did not start");
   pdown_end_a: assert property (
      (seq_q == ECD_PWRDN && tDone && !autoSeq_q)
      |=> (busyN && !poweredOn_q))
      else $error("power-down end wrong");
   pdown_gate_a: assert property (
      (isCmd && seqIdle && !poweredOn_q && rxb == `ECD_C_PDOWN)
      |=> seqIdle) else $error("power-down ran while off");
   pup_busy_a: assert property (
      goPup |=> (!busyN)[*8]) else $error("power-up busy too short");
   pup_ready_a: assert property (
      (seq_q == ECD_PWRUP && tDone && !autoSeq_q)
      |=> (busyN && poweredOn_q)) else $error("power-up end wrong");
   sleep_key_a: assert property (
      (prm && seqIdle && cmd_q == `ECD_C_SLEEP
       && rxb != `ECD_SLEEP_KEY) |=> $stable(deepSleep_q))
      else $error("sleep without key");
   sleep_hold_a: assert property (
      deepSleep_q |=> deepSleep_q) else $error("sleep left");
   auto_busy_a: assert property (
      autoSeq_q |-> !busyN) else $error("busy high in auto run");
   img_addr_a: assert property (
      imgWr |=> wrAddr_q == $past(wrAddr_q) + 1'b1)
      else $error("image address not stepped");
   border_upd_a: assert property (
      (pOne && cmd_q == `ECD_C_BORDER)
      |=> borderSel == $past(rxb[7:5])) else $error("border lost");
   temp_busy_a: assert property (
      goTemp |=> (tempSensorEn && !busyN)) else $error("temp no busy");
   vsense_on_a: assert property (
      seq_q == ECD_VSENSE |-> poweredOn_q) else $error("sense off");
   otp_on_a: assert property (
      seq_q == ECD_OTPWR |-> poweredOn_q) else $error("otp write off");
   unknown_a: assert property (
      (isCmd && !known) |=> !cmdVld_q) else $error("unknown taken");
endmodule

// file: ecd_host_model.sv
// host model that drives the serial command link
`timescale 1ns/10ps
module ecd_host_model (
   output logic      sclk,
   output logic      csN,
   output logic      dcSel,
   output logic      sdaIn,
   input  wire logic sdaOut
);
   initial begin
      sclk = 0;
      csN = 1;
      dcSel = 1;
      sdaIn = 0;
   end
   // clock idles low between bytes; released lines flip so stale bits fail
   task automatic xfer(input logic dc, input logic [7:0] wb,
                       output logic [7:0] rb);
      csN = 0;
      dcSel = dc;
      for (int i = 7; i >= 0; i--) begin
         sdaIn = wb[i];
         #3 rb[i] = sdaOut;
         sclk = 1;
         #3 sclk = 0;
      end
      #3 csN = 1;
      dcSel = ~dc;
      sdaIn = ~sdaIn;
   endtask
endmodule

// file: epaper_command_decoder_tb.sv
// self-checking bench of the panel command decoder
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
   num_errors++; $display("FAIL %s exp %h got %h", n, e, a); end end
module epaper_command_decoder_tb;
   localparam logic [7:0] VerId = 8'h3c; // arbitrary value
   logic             mclk = 0, resetn = 0, psrResWr = 0;
   logic [7:0]       tempValue = 0, r, c, img[256];
   logic [5:0]       vcomSense = 0;
   logic [9:0]       psrHres = 0, psrVres = 0, h;
   wire logic        sclk, csN, dcSel, sdaIn, sdaOut, sdaOe, busyN;
   wire logic        powerOn, tempSensorEn, deepSleep, programMode;
   wire logic        otpProgStart, borderHiZ, srcValid;
   wire logic [15:0] otpAddr;
   wire logic [9:0]  horizontal_resolution, vertical_resolution;
   wire logic [7:0]  vcomDc, vcomAutoCfg, powerSaving;
   wire logic [7:0]  otpRdData = otpAddr[7:0] ^ 8'h5a;
   wire logic [2:0]  borderSel;
   wire logic [1:0]  srcLevel;
   int               num_errors = 0, compares = 0, npix = 0, nprog = 0;
   int               ntemp = 0, noe = 0;
   always #4 mclk = ~mclk;
   ecd_decoder #(.AW(8), .DEPTH(256), .PON_CYC(20), .SEC_CYC(10),
      .VER_ID(VerId)) u_dut (.mclk, .resetn, .sclk,
      .csN, .dcSel, .sdaIn, .sdaOut, .sdaOe, .busyN, .powerOn,
      .tempSensorEn, .deepSleep, .programMode, .otpProgStart, .otpAddr,
      .otpRdData, .tempValue, .vcomSense, .psrResWr, .psrHres, .psrVres,
      .horizontal_resolution, .vertical_resolution, .borderSel, .borderHiZ, .vcomDc, .vcomAutoCfg,
      .powerSaving, .srcLevel, .srcValid);
   ecd_host_model u_host (.sclk, .csN, .dcSel, .sdaIn, .sdaOut);
   function automatic logic [1:0] pix(int k);
      logic [7:0] b;
      b = img[k / 4];
      return b[7 - 2 * (k % 4) -: 2];
   endfunction
   // every refresh, auto ones too, scans the same stored image
   always @(negedge mclk) begin
      if (otpProgStart === 1'b1) nprog++;
      if (tempSensorEn === 1'b1) ntemp++;
      if (sdaOe === 1'b1) noe++;
      if (srcValid === 1'b1) begin
         `CHK("srcLevel", pix(npix % (h * 120)), srcLevel)
         npix++;
      end
   end
   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(logic dc, logic [7:0] b);
      logic [7:0] x;
      u_host.xfer(dc, b, x);
      repeat (8) @(negedge mclk);
   endtask
   task automatic rd(logic [7:0] e, string n);
      u_host.xfer(1'b1, 8'hff, r);
      repeat (8) @(negedge mclk);
      `CHK(n, e, r)
   endtask
   task automatic op(logic [7:0] cm, logic hp, logic [7:0] p, logic bz);
      wr(1'b0, cm);
      if (hp) wr(1'b1, p);
      `CHK("busyN", ~bz, busyN)
      for (int i = 0; busyN !== 1'b1; i++)
         if (i > 5000) begin
            num_errors++;
            close_out();
         end else @(negedge mclk);
   endtask
   task automatic rst();
      resetn = 0;
      repeat (3) @(negedge mclk);
      resetn = 1;
      repeat (3) @(negedge mclk);
   endtask
   // ****
   // scenarios
   // ****
   initial begin
      void'($urandom(19));
      h = 10'(4 * (1 + $urandom % 2));
      repeat (20) @(negedge mclk);
      resetn = 1;
      repeat (3) @(negedge mclk);
      `CHK("border", 3'h4, borderSel)
      `CHK("vauto", 8'h00, vcomAutoCfg)
      `CHK("vdc", 8'h00, vcomDc)
      `CHK("horizontal_resolution", 10'h3c0, horizontal_resolution)
      `CHK("vertical_resolution", 10'h2a8, vertical_resolution)
      `CHK("psave", 8'h65, powerSaving)
      op(8'h02, 0, 0, 0);
      wr(0, 8'h50);
      wr(0, 8'h33);
      wr(1, 8'h00);
      `CHK("hiz", 1'b1, borderHiZ)
      psrHres = 10'($urandom);
      psrVres = 10'($urandom);
      psrResWr = 1;
      @(negedge mclk) psrResWr = 0;
      repeat (3) @(negedge mclk);
      `CHK("horizontal_resolution", psrHres, horizontal_resolution)
      `CHK("vertical_resolution", psrVres, vertical_resolution)
      wr(0, 8'h61);
      wr(1, {6'h0, h[9:8]});
      wr(1, h[7:0]);
      wr(1, 8'h00);
      wr(1, 8'd120);
      `CHK("horizontal_resolution", h, horizontal_resolution)
      `CHK("vertical_resolution", 10'd120, vertical_resolution)
      for (int i = 0; i < 5; i++) begin
         wr(0, 8'h50);
         wr(1, {i[2:0], 5'h00});
         `CHK("border", i[2:0], borderSel)
         `CHK("hiz", i == 4, borderHiZ)
      end
      c = 8'($urandom);
      wr(0, 8'h82);
      wr(1, c);
      `CHK("vdc", c, vcomDc)
      wr(0, 8'he3);
      wr(1, c);
      `CHK("psave", c, powerSaving)
      `CHK("oe", 0, noe)
      $display("test settings done");
      wr(0, 8'h10);
      for (int k = 0; k < h * 30; k++) begin
         img[k] = 8'($urandom);
         wr(1, img[k]);
      end
      op(8'h04, 0, 0, 1);
      `CHK("pwr", 1'b1, powerOn)
      op(8'h12, 0, 0, 1);
      wr(1, 8'h00);
      `CHK("npix", h * 120, npix)
      vcomSense = 6'($urandom);
      c = 8'($urandom) & 8'hf1 | 8'h01;
      op(8'h80, 1, c, 1);
      `CHK("vauto", c, vcomAutoCfg)
      wr(0, 8'h81);
      rd({2'b10, vcomSense}, "vcom");
      tempValue = 8'he7 + 8'($urandom % 76);
      op(8'h40, 0, 0, 1);
      `CHK("tsen", 1'b1, ntemp > 0)
      `CHK("tsen", 1'b0, tempSensorEn)
      rd(tempValue, "temp");
      wr(0, 8'h70);
      rd(VerId, "ver");
      `CHK("oe", 1'b1, noe > 0)
      wr(0, 8'h92);
      rd(8'h00, "dummy");
      rd(8'h5a, "otp0");
      rd(8'h5b, "otp1");
      op(8'h91, 0, 0, 1);
      op(8'h02, 0, 0, 1);
      `CHK("pwr", 1'b0, powerOn)
      op(8'h91, 0, 0, 0);
      `CHK("prog", 1, nprog)
      $display("test image and reads done");
      op(8'h17, 1, 8'h11, 0);
      op(8'h17, 1, 8'ha5, 1);
      `CHK("sleep", 1'b0, deepSleep)
      op(8'h17, 1, 8'ha7, 1);
      `CHK("sleep", 1'b1, deepSleep)
      `CHK("npix", 3 * h * 120, npix)
      wr(0, 8'h50);
      wr(1, 8'h00);
      `CHK("border", 3'h4, borderSel)
      rst();
      op(8'h07, 1, 8'h5a, 0);
      `CHK("sleep", 1'b0, deepSleep)
      op(8'h07, 1, 8'ha5, 0);
      `CHK("sleep", 1'b1, deepSleep)
      rst();
      op(8'h90, 0, 0, 1);
      `CHK("pgm", 1'b1, programMode)
      rst();
      `CHK("pgm", 1'b0, programMode)
      $display("test sequences done");
      close_out();
   end
endmodule
